// file: rtl/bem_pkg.sv
// Purpose: Shared constants of the bus error monitor.
// Assumes: Reference clock of 10 MHz; AXI4-Lite register access.
// Notes:   Flags sit in the low bits of the status word.
////////////////////////////////////////////////////////////////////////////////
package bem_pkg;
  // Clock and time
  localparam int CLK_PERIOD_NS = 100;
  localparam int TIMEOUT_US    = 25000;
  // Longest wait rounds down to whole cycles
  localparam int TIMEOUT_CYC   = (TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  // Register map
  localparam int         ADDR_W     = 4;
  localparam logic [3:0] STATUS_OFS = 4'h0;
  localparam logic [3:0] CTRL_OFS   = 4'h4;
  // Status fields
  localparam int         FLAG_W      = 6;
  localparam int         TIMEOUT_BIT = 0;
  localparam int         RDTR_BIT    = 1;
  localparam int         NOISE_BIT   = 2;
  localparam int         GLITCH_BIT  = 3;
  localparam int         DCONT_BIT   = 4;
  localparam int         ACONT_BIT   = 5;
  localparam logic [5:0] FLAGS_RST   = 6'h00;
  // Control fields
  localparam int         CTRL_W      = 2;
  localparam int         CTRL_RR_BIT = 0;
  localparam int         CTRL_TO_BIT = 1;
  localparam logic [1:0] CTRL_RST    = 2'h0;
  // Oversampling monitor
  localparam int   FILT_SAMPLES = 3;
  localparam int   NOISE_WINDOW = 16;
  localparam logic LINE_IDLE    = 1'b1;
  // Events crossing from the link domain
  localparam int EV_N     = 5;
  localparam int EV_ACONT = 0;
  localparam int EV_DCONT = 1;
  localparam int EV_GLT   = 2;
  localparam int EV_NOISE = 3;
  localparam int EV_RX    = 4;
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : bem_pkg

// file: rtl/bem_sync.sv
// Purpose: Two flip-flop level synchroniser, one per bit.
// Assumes: Inputs are levels that hold for several destination cycles.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/100ps
module bem_sync #(
  parameter int W = 1
) (
  // Destination clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  ////////////////////////////////////////////////////////////////////////////////
  // Two stages against metastability
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : bem_sync

// file: rtl/bem_lane.sv
// Purpose: Oversampling monitor of one bus line on the link clock.
// Assumes: Inputs already synchronised to link_clk.
// Notes:   quiet marks intervals where the line should be settled.
`timescale 1ns/100ps
module bem_lane
  import bem_pkg::*;
#(
  parameter int FILT_N    = bem_pkg::FILT_SAMPLES,
  parameter int NOISE_WIN = bem_pkg::NOISE_WINDOW
) (
  // Link clock and reset
  input  wire logic link_clk,
  input  wire logic link_rst_b,
  // Line sample and expected level
  input  wire logic smp,
  input  wire logic drv_chk,
  input  wire logic drv_val,
  input  wire logic quiet,
  // Event pulses
  output logic      cont,
  output logic      glitch,
  output logic      noise
);
  localparam int CW = $clog2(NOISE_WIN + 1);
  localparam logic [CW+1:0] WIN_REF = (CW+2)'(NOISE_WIN);

  logic          filt, next_filt;
  logic [CW-1:0] run, next_run;
  logic [CW-1:0] wcnt, next_wcnt;
  logic [CW-1:0] dcnt, next_dcnt;
  logic          next_cont, next_glitch, next_noise;
  logic          mis;

  assign mis = (smp != filt);

  ////////////////////////////////////////////////////////////////////////////////
  // Filter, glitch run and noise window
  always_comb begin
    next_filt   = filt;
    next_run    = '0;
    next_wcnt   = '0;
    next_dcnt   = '0;
    next_noise  = 1'b0;
    // Filter follows the line after FILT_N agreeing samples
    if (mis) begin
      next_run = run + 1'b1;
      if (next_run == CW'(FILT_N)) begin
        next_filt = smp;
        next_run  = '0;
      end
    end
    // Contention only where the line should be settled
    next_cont   = quiet && drv_chk && (smp != drv_val);
    // Second disagreeing sample in a row; slow edges land here too
    next_glitch = quiet && mis && (run != '0);
    if (quiet) begin
      next_wcnt = wcnt + 1'b1;
      next_dcnt = dcnt + CW'(mis);
      if (wcnt == CW'(NOISE_WIN - 1)) begin
        next_noise = ({next_dcnt, 2'b00} > WIN_REF);
        next_wcnt  = '0;
        next_dcnt  = '0;
      end
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      filt   <= LINE_IDLE;
      run    <= '0;
      wcnt   <= '0;
      dcnt   <= '0;
      cont   <= 1'b0;
      glitch <= 1'b0;
      noise  <= 1'b0;
    end else begin
      filt   <= next_filt;
      run    <= next_run;
      wcnt   <= next_wcnt;
      dcnt   <= next_dcnt;
      cont   <= next_cont;
      glitch <= next_glitch;
      noise  <= next_noise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_lane_cont;
    @(posedge link_clk) disable iff (!link_rst_b)
      (quiet && drv_chk && smp != drv_val) |=> cont;
  endproperty
  a_lane_cont: assert property (p_lane_cont)
    else $error("Settled mismatch without contention pulse");

  property p_lane_glitch;
    @(posedge link_clk) disable iff (!link_rst_b)
      (quiet && mis)[*2] ##0 $stable(filt) |=> glitch;
  endproperty
  a_lane_glitch: assert property (p_lane_glitch)
    else $error("Two disagreeing samples without glitch pulse");

  property p_lane_noise;
    @(posedge link_clk) disable iff (!link_rst_b)
      noise |-> $past(quiet) && ($past(wcnt) == CW'(NOISE_WIN - 1));
  endproperty
  a_lane_noise: assert property (p_lane_noise)
    else $error("Noise pulse outside window end");

  c_lane_glitch: cover property (@(posedge link_clk) disable iff (!link_rst_b) glitch);
endmodule : bem_lane

// file: rtl/bem_top.sv
// Purpose: Error flags of the bus master, with AXI4-Lite register access.
// Assumes: Sequencer signals are on ref_clk; pins and filters are asynchronous.
// Notes:   Bus lines are oversampled on link_clk; events cross by toggles.
`timescale 1ns/100ps
module bem_top
  import bem_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = bem_pkg::TIMEOUT_CYC,
  parameter int FILT_N         = bem_pkg::FILT_SAMPLES,
  parameter int NOISE_WIN      = bem_pkg::NOISE_WINDOW
) (
  // Clocks and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst_b,
  input  wire logic                     link_clk,
  // AXI4-Lite write
  input  wire logic [bem_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // AXI4-Lite read
  input  wire logic [bem_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // Bus lines, raw and analog filtered
  input  wire logic                     scl_pin,
  input  wire logic                     sda_pin,
  input  wire logic                     scl_afilt,
  input  wire logic                     sda_afilt,
  // Sequencer state
  input  wire logic                     scl_drv_val,
  input  wire logic                     sda_drv_en,
  input  wire logic                     sda_drv_val,
  input  wire logic                     bus_settled,
  input  wire logic                     xfer_busy,
  input  wire logic                     rd_word_valid,
  input  wire logic [31:0]              rd_word,
  input  wire logic                     rd_second,
  // Results
  output logic                          rx_bit,
  output logic                          rx_bit_valid,
  output logic [bem_pkg::FLAG_W-1:0]    err_flags
);
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain reset: asserted at once, released on link_clk
  logic link_rst_m, link_rst_b;

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      link_rst_m <= 1'b0;
      link_rst_b <= 1'b0;
    end else begin
      link_rst_m <= 1'b1;
      link_rst_b <= link_rst_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain: synchronised lines and drive state
  logic [3:0]      pin_s;   // sda_af, scl_af, sda, scl
  logic [3:0]      pin_n;   // Inverted copy, so reset reads as idle high
  logic [3:0]      ctl_s;   // settled, sda_val, sda_en, scl_val
  logic            scl_af_d, next_scl_af_d;
  logic            rx_data, next_rx_data;
  logic [EV_N-1:0] ev_tgl, next_ev_tgl;
  logic [1:0]      l_chk, l_val, l_cont, l_glt, l_noise;
  logic            af_rise;

  bem_sync #(.W(4)) u_pin_sync (
    .clk   (link_clk),
    .rst_b (link_rst_b),
    .d     (~{sda_afilt, scl_afilt, sda_pin, scl_pin}),
    .q     (pin_n)
  );

  // Lines idle high; a zero after reset would fake a filtered SCL rise
  assign pin_s = ~pin_n;

  bem_sync #(.W(4)) u_ctl_sync (
    .clk   (link_clk),
    .rst_b (link_rst_b),
    .d     ({bus_settled, sda_drv_val, sda_drv_en, scl_drv_val}),
    .q     (ctl_s)
  );

  // SCL is always ours to check, SDA only while driven
  assign l_chk = {ctl_s[1], 1'b1};
  assign l_val = {ctl_s[2], ctl_s[0]};

  for (genvar g = 0; g < 2; g++) begin : g_lane
    bem_lane #(.FILT_N(FILT_N), .NOISE_WIN(NOISE_WIN)) u_lane (
      .link_clk   (link_clk),
      .link_rst_b (link_rst_b),
      .smp        (pin_s[g]),
      .drv_chk    (l_chk[g]),
      .drv_val    (l_val[g]),
      .quiet      (ctl_s[3]),
      .cont       (l_cont[g]),
      .glitch     (l_glt[g]),
      .noise      (l_noise[g])
    );
  end

  assign af_rise = pin_s[2] && !scl_af_d;

  // Analog check and read capture share the filtered clock edge
  always_comb begin
    next_scl_af_d = pin_s[2];
    next_rx_data  = rx_data;
    next_ev_tgl   = ev_tgl;
    if (af_rise && ctl_s[1] && (pin_s[3] != ctl_s[2])) begin
      next_ev_tgl[EV_ACONT] = !ev_tgl[EV_ACONT];
    end
    if (af_rise && !ctl_s[1]) begin
      next_rx_data       = pin_s[3];
      next_ev_tgl[EV_RX] = !ev_tgl[EV_RX];
    end
    next_ev_tgl[EV_DCONT] = ev_tgl[EV_DCONT] ^ (|l_cont);
    next_ev_tgl[EV_GLT]   = ev_tgl[EV_GLT] ^ (|l_glt);
    next_ev_tgl[EV_NOISE] = ev_tgl[EV_NOISE] ^ (|l_noise);
  end

  always_ff @(posedge link_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      scl_af_d <= LINE_IDLE;
      rx_data  <= 1'b0;
      ev_tgl   <= '0;
    end else begin
      scl_af_d <= next_scl_af_d;
      rx_data  <= next_rx_data;
      ev_tgl   <= next_ev_tgl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Crossing: toggles into ref_clk, edges become one-cycle pulses
  logic [EV_N-1:0] ev_s, ev_d, ev_pulse;

  bem_sync #(.W(EV_N)) u_ev_sync (
    .clk   (ref_clk),
    .rst_b (rst_b),
    .d     (ev_tgl),
    .q     (ev_s)
  );

  assign ev_pulse = ev_s ^ ev_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Timeout, redundant read and sticky flags
  logic [TW-1:0]     to_cnt, next_to_cnt;
  logic [31:0]       first_word, next_first_word;
  logic [FLAG_W-1:0] flags, next_flags, set_vec;
  logic [CTRL_W-1:0] ctrl, next_ctrl;
  logic              next_rx_bit, to_hit, rr_mis;
  logic              aw_got, w_got, wr_do, wr_status;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;

  assign to_hit = xfer_busy && (to_cnt == TW'(TIMEOUT_CYCLES - 1));
  assign rr_mis = rd_word_valid && rd_second && ctrl[CTRL_RR_BIT]
                  && (rd_word != first_word);
  assign wr_do     = aw_got && w_got;
  assign wr_status = wr_do && (aw_addr == STATUS_OFS) && w_strb[0];

  // Hardware sets win over a clearing write in the same cycle
  always_comb begin
    set_vec              = '0;
    set_vec[ACONT_BIT]   = ev_pulse[EV_ACONT];
    set_vec[DCONT_BIT]   = ev_pulse[EV_DCONT];
    set_vec[GLITCH_BIT]  = ev_pulse[EV_GLT];
    set_vec[NOISE_BIT]   = ev_pulse[EV_NOISE];
    set_vec[RDTR_BIT]    = rr_mis;
    set_vec[TIMEOUT_BIT] = to_hit && ctrl[CTRL_TO_BIT];
    next_flags = flags;
    if (wr_status) begin
      next_flags = flags & s_axi_wdata_q();
    end
    next_flags = next_flags | set_vec;
    next_ctrl  = ctrl;
    if (wr_do && (aw_addr == CTRL_OFS) && w_strb[0]) begin
      next_ctrl = w_data[CTRL_W-1:0];
    end
    // Counter stops once past the limit, so one overrun sets once
    next_to_cnt = '0;
    if (xfer_busy) begin
      next_to_cnt = (to_cnt == TW'(TIMEOUT_CYCLES)) ? to_cnt : to_cnt + 1'b1;
    end
    next_first_word = first_word;
    if (rd_word_valid && !rd_second) begin
      next_first_word = rd_word;
    end
    next_rx_bit = ev_pulse[EV_RX] ? rx_data : rx_bit;
  end

  function automatic logic [FLAG_W-1:0] s_axi_wdata_q();
    return w_data[FLAG_W-1:0];
  endfunction : s_axi_wdata_q

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ev_d         <= '0;
      to_cnt       <= '0;
      first_word   <= '0;
      flags        <= FLAGS_RST;
      ctrl         <= CTRL_RST;
      rx_bit       <= 1'b0;
      rx_bit_valid <= 1'b0;
    end else begin
      ev_d         <= ev_s;
      to_cnt       <= next_to_cnt;
      first_word   <= next_first_word;
      flags        <= next_flags;
      ctrl         <= next_ctrl;
      rx_bit       <= next_rx_bit;
      rx_bit_valid <= ev_pulse[EV_RX];
    end
  end

  assign err_flags = flags;

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data taken in either order
  logic              next_aw_got, next_w_got, next_bvalid, next_rvalid;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [31:0]       next_w_data, next_rdata;
  logic [3:0]        next_w_strb;
  logic [1:0]        next_bresp, next_rresp;

  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready  = !w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    next_aw_got  = aw_got;
    next_aw_addr = aw_addr;
    next_w_got   = w_got;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid && !s_axi_bready;
    next_bresp   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got  = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got  = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_do) begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = (aw_addr == STATUS_OFS || aw_addr == CTRL_OFS) ? RESP_OKAY
                                                                  : RESP_SLVERR;
    end
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      case (s_axi_araddr)
        STATUS_OFS: next_rdata = {{(32-FLAG_W){1'b0}}, flags};
        CTRL_OFS:   next_rdata = {{(32-CTRL_W){1'b0}}, ctrl};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_got       <= 1'b0;
      aw_addr      <= '0;
      w_got        <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else begin
      aw_got       <= next_aw_got;
      aw_addr      <= next_aw_addr;
      w_got        <= next_w_got;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_sticky_hold;
    @(posedge ref_clk) disable iff (!rst_b)
      !wr_status |=> ((flags & $past(flags)) == $past(flags));
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("Flag dropped without a clearing write");

  property p_clear_zero;
    @(posedge ref_clk) disable iff (!rst_b)
      (wr_status && set_vec == '0) |=> (flags == ($past(flags) & $past(w_data[FLAG_W-1:0])));
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("Status write did not clear exactly the zero bits");

  property p_set_wins;
    @(posedge ref_clk) disable iff (!rst_b)
      (set_vec != '0) |=> ((flags & $past(set_vec)) == $past(set_vec));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Event lost against a clear");

  property p_rr_off;
    @(posedge ref_clk) disable iff (!rst_b)
      (!ctrl[CTRL_RR_BIT] && !flags[RDTR_BIT]) |=> !flags[RDTR_BIT];
  endproperty
  a_rr_off: assert property (p_rr_off)
    else $error("Redundant read error while disabled");

  property p_rr_mis;
    @(posedge ref_clk) disable iff (!rst_b)
      (rd_word_valid && rd_second && ctrl[CTRL_RR_BIT] && rd_word != first_word)
      |=> flags[RDTR_BIT];
  endproperty
  a_rr_mis: assert property (p_rr_mis)
    else $error("Read mismatch not flagged");

  property p_to_off;
    @(posedge ref_clk) disable iff (!rst_b)
      (!ctrl[CTRL_TO_BIT] && !flags[TIMEOUT_BIT]) |=> !flags[TIMEOUT_BIT];
  endproperty
  a_to_off: assert property (p_to_off)
    else $error("Timeout flagged while disabled");

  property p_to_fire;
    @(posedge ref_clk) disable iff (!rst_b)
      (xfer_busy && ctrl[CTRL_TO_BIT] && to_cnt == TW'(TIMEOUT_CYCLES - 1))
      |=> flags[TIMEOUT_BIT];
  endproperty
  a_to_fire: assert property (p_to_fire)
    else $error("Overrun not flagged");

  property p_acont;
    @(posedge link_clk) disable iff (!link_rst_b)
      (af_rise && ctl_s[1] && pin_s[3] != ctl_s[2]) |=> $changed(ev_tgl[EV_ACONT]);
  endproperty
  a_acont: assert property (p_acont)
    else $error("Analog contention not signalled");

  property p_ev_lat;
    @(posedge ref_clk) disable iff (!rst_b)
      ev_pulse[EV_ACONT] |=> flags[ACONT_BIT];
  endproperty
  a_ev_lat: assert property (p_ev_lat)
    else $error("Crossed contention event not flagged");

  c_timeout: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(flags[TIMEOUT_BIT]));
  c_rr_mis:  cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(flags[RDTR_BIT]));
  c_acont:   cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(flags[ACONT_BIT]));
  c_rx:      cover property (@(posedge ref_clk) disable iff (!rst_b) rx_bit_valid);
endmodule : bem_top

// file: test/bem_bus_model.sv
// Purpose: Slave and pull-up on SDA; SCL follows the master drive.
// Assumes: Open-drain lines idle high through pull-ups.
// Notes:   The analog filter is an inertial delay; noisy adds a fast toggle.
`timescale 1ns/100ps
module bem_bus_model (
  // Master side
  input  wire logic scl_drv_val,
  input  wire logic sda_drv_en,
  input  wire logic sda_drv_val,
  // Slave behaviour
  input  wire logic slv_low,
  input  wire logic noisy,
  // Line levels
  output logic      scl_pin,
  output logic      sda_pin,
  output logic      scl_afilt,
  output logic      sda_afilt
);
  logic jit = 1'b0;
  logic sda;
  // Free toggle, not tied to either clock
  always #20 jit = ~jit;
  // Wired-AND: any party pulling low wins over the pull-up
  assign sda = (sda_drv_en ? sda_drv_val : 1'b1) & ~slv_low;
  assign scl_pin = scl_drv_val;
  assign sda_pin = sda ^ (noisy & jit);
  // Filter swallows pulses shorter than 40 ns
  assign #40 scl_afilt = scl_pin;
  assign #40 sda_afilt = sda;
endmodule : bem_bus_model

// file: test/tb_top.sv
// Purpose: Self-checking bench of the bus error monitor.
// Assumes: Timeout shortened to 40 cycles.
// Notes:   Read data and captured bits are checked from queues.
`timescale 1ns/100ps
module tb_top;
  import bem_pkg::*;
  localparam int TO = 40;
  logic ref_clk, link_clk, rst_b, slv_low, noisy, b;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_word, w;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic scl_pin, sda_pin, scl_afilt, sda_afilt, scl_drv_val, sda_drv_en, sda_drv_val;
  logic bus_settled, xfer_busy, rd_word_valid, rd_second, rx_bit, rx_bit_valid;
  logic [FLAG_W-1:0] err_flags;
  logic [65:0] exp_q[$], e;
  logic rx_q[$];
  logic [1:0] br_q[$];
  int mismatches, checks_done;
  bem_top #(.TIMEOUT_CYCLES(TO)) dut (.ref_clk, .rst_b, .link_clk, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .scl_pin, .sda_pin, .scl_afilt, .sda_afilt, .scl_drv_val, .sda_drv_en,
    .sda_drv_val, .bus_settled, .xfer_busy, .rd_word_valid, .rd_word, .rd_second,
    .rx_bit, .rx_bit_valid, .err_flags);
  bem_bus_model bus (.scl_drv_val, .sda_drv_en, .sda_drv_val, .slv_low, .noisy,
    .scl_pin, .sda_pin, .scl_afilt, .sda_afilt);
  // Clocks of unrelated phase
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 0;
    #3;
    forever #7.5 link_clk = ~link_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h want %h", $time, s, got, exp);
    end
  endtask : chk
  // Read answers come in order, so the oldest note matches
  always @(posedge ref_clk) if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
    e = exp_q.pop_front();
    chk({30'h0, s_axi_rresp}, {30'h0, e[65:64]}, "resp");
    chk(s_axi_rdata & e[63:32], e[31:0], "rdata");
  end
  // Write answers likewise come in order
  always @(posedge ref_clk) if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
    chk({30'h0, s_axi_bresp}, {30'h0, br_q.pop_front()}, "bresp");
  end
  always @(posedge ref_clk) if (rx_bit_valid === 1'b1) begin
    chk({31'h0, rx_bit}, {31'h0, rx_q.pop_front()}, "rx bit");
  end
  // Handshakes are judged on values seen before the edge
  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] br = RESP_OKAY);
    logic aw, wd, bd;
    bd = 0;
    br_q.push_back(br);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!bd) begin
      @(negedge ref_clk);
      aw = s_axi_awvalid & s_axi_awready;
      wd = s_axi_wvalid & s_axi_wready;
      bd = s_axi_bvalid;
      @(posedge ref_clk);
      if (aw) s_axi_awvalid <= 0;
      if (wd) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
    // Let an edge pass so a following call never re-drives bready in this step
    @(posedge ref_clk);
  endtask : axw
  task automatic axr(input logic [3:0] a, input logic [31:0] x, m, input logic [1:0] r);
    logic ar, rd;
    rd = 0;
    exp_q.push_back({r, m, x});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!rd) begin
      @(negedge ref_clk);
      ar = s_axi_arvalid & s_axi_arready;
      rd = s_axi_rvalid;
      @(posedge ref_clk);
      if (ar) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
    @(posedge ref_clk);
  endtask : axr
  task automatic busy(input int n);
    xfer_busy <= 1;
    repeat (n) @(posedge ref_clk);
    xfer_busy <= 0;
    repeat (3) @(posedge ref_clk);
  endtask : busy
  task automatic rr(input logic [31:0] d, input logic s);
    rd_word <= d;
    rd_second <= s;
    rd_word_valid <= 1;
    @(posedge ref_clk);
    rd_word_valid <= 0;
    @(posedge ref_clk);
  endtask : rr
  task automatic end_of_test;
    if (exp_q.size() != 0 || rx_q.size() != 0 || br_q.size() != 0) mismatches++;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    #1000000;
    mismatches++;
    end_of_test();
  end
  // Main sequence
  initial begin
    {rst_b, slv_low, noisy, s_axi_awaddr, s_axi_araddr, s_axi_wdata, rd_word} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {sda_drv_en, bus_settled, xfer_busy, rd_word_valid, rd_second} = '0;
    {scl_drv_val, sda_drv_val, s_axi_wstrb} = 6'h3f;
    void'($urandom(32'hd053));
    repeat (20) @(posedge ref_clk);
    rst_b <= 1;
    repeat (4) @(posedge ref_clk);
    axr(STATUS_OFS, 0, '1, RESP_OKAY);
    axr(CTRL_OFS, 0, 32'h3, RESP_OKAY);
    axw(4'h8, '1, RESP_SLVERR);
    axr(4'h8, 0, '1, RESP_SLVERR);
    $display("test reset done");
    axw(CTRL_OFS, 32'h2);
    busy(TO - 1);
    axr(STATUS_OFS, 0, 32'h3f, RESP_OKAY);
    busy(TO + 5);
    chk({26'h0, err_flags}, 32'h1, "flags");
    axr(STATUS_OFS, 32'h1, 32'h3f, RESP_OKAY);
    axw(STATUS_OFS, 32'h3f);
    axr(STATUS_OFS, 32'h1, 32'h3f, RESP_OKAY);
    axw(STATUS_OFS, 0);
    axw(CTRL_OFS, 0);
    busy(TO + 5);
    axr(STATUS_OFS, 0, 32'h3f, RESP_OKAY);
    $display("test timeout done");
    w = $urandom();
    rr(w, 0);
    rr(~w, 1);
    axr(STATUS_OFS, 0, 32'h3f, RESP_OKAY);
    axw(CTRL_OFS, 32'h1);
    rr(w, 0);
    rr(w, 1);
    axr(STATUS_OFS, 0, 32'h3f, RESP_OKAY);
    rr(~w, 1);
    axr(STATUS_OFS, 32'h2, 32'h3f, RESP_OKAY);
    axw(STATUS_OFS, 0);
    $display("test redundant read done");
    sda_drv_en <= 1;
    bus_settled <= 1;
    repeat (6) @(posedge ref_clk);
    slv_low <= 1;
    repeat (10) @(posedge ref_clk);
    bus_settled <= 0;
    scl_drv_val <= 0;
    repeat (3) @(posedge ref_clk);
    scl_drv_val <= 1;
    repeat (8) @(posedge ref_clk);
    slv_low <= 0;
    sda_drv_en <= 0;
    repeat (8) @(posedge ref_clk);
    axr(STATUS_OFS, 32'h30, 32'h30, RESP_OKAY);
    axw(STATUS_OFS, 0);
    $display("test contention done");
    // Slave answers four bits; SDA not driven, so no analog contention
    repeat (4) begin
      b = 1'($urandom());
      slv_low <= ~b;
      scl_drv_val <= 0;
      repeat (3) @(posedge ref_clk);
      rx_q.push_back(b);
      scl_drv_val <= 1;
      repeat (8) @(posedge ref_clk);
    end
    slv_low <= 0;
    axr(STATUS_OFS, 0, 32'h20, RESP_OKAY);
    bus_settled <= 1;
    noisy <= 1;
    repeat (40) @(posedge ref_clk);
    noisy <= 0;
    repeat (8) @(posedge ref_clk);
    axr(STATUS_OFS, 32'h0c, 32'h1c, RESP_OKAY);
    chk({26'h0, err_flags} & 32'h1c, 32'h0c, "flags");
    $display("test capture and noise done");
    end_of_test();
  end
endmodule : tb_top
